// File: logic/fault_readback_pkg.sv
// fault read-back constants: word addresses, field positions, codes
// assumes a 16-bit serial frame, one status word shifted out per frame
package fault_readback_pkg;
  localparam int WORD_W   = 16;
  localparam int NUM_CH   = 5;
  localparam int NUM_IN   = 4;
  localparam int CNT_W    = 5;
  // read addresses
  localparam logic [3:0] ADDR_INIT1   = 4'h0;
  localparam logic [3:0] ADDR_QUICK   = 4'h1;
  localparam logic [3:0] ADDR_CH1     = 4'h2;
  localparam logic [3:0] ADDR_CH5     = 4'h6;
  localparam logic [3:0] ADDR_DEVICE  = 4'h7;
  localparam logic [3:0] ADDR_PINS    = 4'h8;
  localparam logic [3:0] ADDR_PART_ID = 4'h9;
  // common word fields
  localparam int ADDR_MSB  = 15;
  localparam int ADDR_LSB  = 12;
  localparam int FAIL_BIT  = 11;
  localparam int DSF_BIT   = 10;
  localparam int OVERLOAD_FLAG_BIT  = 9;
  localparam int OLF_BIT   = 8;
  // quick word
  localparam int Q_CPF_BIT  = 7;
  localparam int Q_RCF_BIT  = 6;
  localparam int Q_CLOCK_FAIL_FLAG_BIT = 5;
  // channel word
  localparam int C_OTS_BIT   = 6;
  localparam int C_OTW_BIT   = 5;
  localparam int C_OC_LSB    = 2;
  localparam int C_OLON_BIT  = 1;
  localparam int C_OLOFF_BIT = 0;
  // device word
  localparam int D_TMF_BIT  = 4;
  localparam int D_OVF_BIT  = 3;
  localparam int D_UVF_BIT  = 2;
  localparam int D_SERIAL_LINK_FAIL_FLAG_BIT = 1;
  localparam int D_LIMP_BIT = 0;
  // pin word
  localparam int P_TOGGLE_BIT = 9;
  localparam int P_IN_LSB     = 5;
  // write word to init register 1
  localparam int W_SEL_LSB    = 0;
  localparam int W_STICKY_BIT = 4;
  localparam int W_ROUTE_LSB  = 5;
  // overcurrent codes
  localparam logic [2:0] OC_NONE     = 3'h0;
  localparam logic [2:0] OC_HI_WIN1  = 3'h1;
  localparam logic [2:0] OC_HI_WIN2  = 3'h2;
  localparam logic [2:0] OC_HI_WIN3  = 3'h3;
  localparam logic [2:0] OC_LOW_THR  = 3'h4;
  localparam logic [2:0] OC_HI_DEMND = 3'h5;
  localparam logic [2:0] OC_SEVERE   = 3'h6;
  // reset values and frame length
  localparam logic [3:0] SEL_RESET    = ADDR_QUICK;
  localparam logic       STICKY_RESET = 1'b0;
  localparam logic [2:0] ROUTE_RESET  = 3'h0;
  localparam logic [CNT_W-1:0] FRAME_BITS = 5'h10;
endpackage

// File: logic/fault_readback.sv
// serial status read-back of a five-channel high-side switch
// assumes: core_clk domain fault inputs, spi pins from the host (sclk stops outside frames)
// Operation
// - four-bit select written to init register 1 picks the shifted word
// - sticky bit 0: programmed address serves one read, then quick status
// - sticky bit 1: programmed address kept until reprogrammed
// - every word carries its address in 15:12 and fail mode at 11
// - address zero returns quick status with address nibble 0001
// - global flags 10:8 in quick/channel/device words clear with underlying faults
// - device summary is OR of clear, uv, ov, pump, clock, test flags
// - overload is OR of all overcurrent and thermal shutdown flags
// - register-clear flag set when all serial registers are at reset
// - channel summary bit is OR of that channel's fault flags, ch5 at bit4
// - channel word: res, shutdown, warning, oc code 4:2, open-on, open-off
// - overcurrent code encodes none, three high windows, low, demand, severe short
// - newer overcurrent event overwrites unread code
// - device word: res 7:5, test, ov, uv, link fail, limp input
// - limp input bit is live level through two synchronizer flops, not latched
// - pin word: toggle OR at 9, inputs 8:5, outputs 4:0, live
// - output bits show above half supply, valid only without undervoltage
// - id word: zeros 10:8, part code 7:0, reads 00 during undervoltage
// - three-bit route select steers feedback, withheld in fail and sleep
module fault_readback
  import fault_readback_pkg::*;
#(
  parameter logic [7:0] PART_CODE = 8'h5a  // arbitrary value
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              spiClk,
  input  wire logic              chipSelN,
  input  wire logic              serialIn,
  output logic                   serialOut,
  output logic                   serialOutEn,
  input  wire logic              failMode,
  input  wire logic              sleepMode,
  input  wire logic [NUM_CH-1:0] ocEvent,
  input  wire logic [3*NUM_CH-1:0] ocEventCode,
  input  wire logic [NUM_CH-1:0] thermalShutdownEvent,
  input  wire logic [NUM_CH-1:0] thermalWarningEvent,
  input  wire logic [NUM_CH-1:0] openLoadOnEvent,
  input  wire logic [NUM_CH-1:0] openLoadOffEvent,
  input  wire logic              chargePumpEvent,
  input  wire logic              clockFailEvent,
  input  wire logic              testModeEvent,
  input  wire logic              overvoltageEvent,
  input  wire logic              undervoltageEvent,
  input  wire logic              limpHomePin,
  input  wire logic [NUM_IN-1:0] controlInputPin,
  input  wire logic [NUM_IN-1:0] inputTogglePin,
  input  wire logic [NUM_CH-1:0] outputPinPin,
  output logic [2:0]             senseRouteSelect,
  output logic                   feedbackEnable
);

  // ---------------- link domain ----------------
  logic [WORD_W-1:0] rxShift_q;
  logic [CNT_W-1:0]  rxCount_q;
  logic [CNT_W-1:0]  txIndex_q;
  logic [WORD_W-1:0] snapWord_q;
  logic              frameArmed_q;

  always_ff @(posedge spiClk) begin
    rxShift_q <= {rxShift_q[WORD_W-2:0], serialIn};
  end

  // armed while chip select is high, cleared by the first rising edge of a frame
  always_ff @(posedge spiClk or posedge chipSelN) begin
    if (chipSelN) begin
      frameArmed_q <= 1'b1;
    end else begin
      frameArmed_q <= 1'b0;
    end
  end

  // count restarts on the first edge of a frame and then stands after
  // chip select rises, so the core domain can still judge the frame length
  always_ff @(posedge spiClk) begin
    if (frameArmed_q) begin
      rxCount_q <= 5'h01;
    end else if (rxCount_q != 5'h1f) begin
      rxCount_q <= rxCount_q + 5'h01;
    end
  end

  always_ff @(negedge spiClk or posedge chipSelN) begin
    if (chipSelN) begin
      txIndex_q <= '0;
    end else if (txIndex_q != 5'h1f) begin
      txIndex_q <= txIndex_q + 5'h01;
    end
  end

  // snapshot only changes while the link is idle
  always_comb begin
    if (chipSelN || txIndex_q >= FRAME_BITS) begin
      serialOut = 1'b0;
    end else begin
      serialOut = snapWord_q[4'(ADDR_MSB - int'(txIndex_q))];
    end
  end
  assign serialOutEn = ~chipSelN;

  // ---------------- core domain ----------------
  logic csSync1_q;
  logic csSync2_q;
  logic csPrev_q;
  logic frameEnd;
  logic frameOk;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      csSync1_q <= 1'b1;
      csSync2_q <= 1'b1;
      csPrev_q  <= 1'b1;
    end else begin
      csSync1_q <= chipSelN;
      csSync2_q <= csSync1_q;
      csPrev_q  <= csSync2_q;
    end
  end
  // rx word and count are frozen once chip select is high again
  assign frameEnd = csSync2_q & ~csPrev_q;
  assign frameOk  = frameEnd && (rxCount_q == FRAME_BITS);

  // pin inputs through two flops
  logic [NUM_IN+NUM_IN+NUM_CH:0] pinSync1_q;
  logic [NUM_IN+NUM_IN+NUM_CH:0] pinSync2_q;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pinSync1_q <= '0;
      pinSync2_q <= '0;
    end else begin
      pinSync1_q <= {limpHomePin, controlInputPin, inputTogglePin, outputPinPin};
      pinSync2_q <= pinSync1_q;
    end
  end
  logic              limpLive;
  logic [NUM_IN-1:0] ctrlLive;
  logic [NUM_IN-1:0] toggleLive;
  logic [NUM_CH-1:0] outLive;
  assign {limpLive, ctrlLive, toggleLive, outLive} = pinSync2_q;

  // selection registers
  logic [3:0] readSel_q;
  logic       sticky_q;
  logic [3:0] snapAddr_q;
  logic       initWrite;
  assign initWrite = frameOk && (rxShift_q[ADDR_MSB:ADDR_LSB] == ADDR_INIT1);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      readSel_q        <= SEL_RESET;
      sticky_q         <= STICKY_RESET;
      senseRouteSelect <= ROUTE_RESET;
    end else if (initWrite) begin
      readSel_q        <= rxShift_q[W_SEL_LSB +: 4];
      sticky_q         <= rxShift_q[W_STICKY_BIT];
      senseRouteSelect <= rxShift_q[W_ROUTE_LSB +: 3];
    end else if (frameOk && !sticky_q) begin
      readSel_q <= ADDR_QUICK;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      feedbackEnable <= 1'b0;
    end else begin
      feedbackEnable <= ~failMode & ~sleepMode;
    end
  end

  // clear-on-read strobes for the word just shifted
  logic [NUM_CH-1:0] chRead;
  logic              devRead;
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      chRead[i] = frameOk && (snapAddr_q == ADDR_CH1 + 4'(i));
    end
    devRead = frameOk && (snapAddr_q == ADDR_DEVICE);
  end

  // per-channel latched faults; set wins over clear
  logic [NUM_CH-1:0] ots_q;
  logic [NUM_CH-1:0] otw_q;
  logic [NUM_CH-1:0] olOn_q;
  logic [NUM_CH-1:0] olOff_q;
  logic [2:0]        ocCode_q [NUM_CH];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ots_q <= '0;
    end else begin
      ots_q <= (ots_q & ~chRead) | thermalShutdownEvent;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      otw_q <= '0;
    end else begin
      otw_q <= (otw_q & ~chRead) | thermalWarningEvent;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      olOn_q <= '0;
    end else begin
      olOn_q <= (olOn_q & ~chRead) | openLoadOnEvent;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      olOff_q <= '0;
    end else begin
      olOff_q <= (olOff_q & ~chRead) | openLoadOffEvent;
    end
  end

  always_ff @(posedge core_clk) begin
    for (int i = 0; i < NUM_CH; i++) begin
      if (rst) begin
        ocCode_q[i] <= OC_NONE;
      end else if (ocEvent[i]) begin
        ocCode_q[i] <= ocEventCode[3*i +: 3];
      end else if (chRead[i]) begin
        ocCode_q[i] <= OC_NONE;
      end
    end
  end

  // device flags
  logic cpf_q;
  logic clock_fail_flag_q;
  logic tmf_q;
  logic ovf_q;
  logic uvf_q;
  logic serial_link_fail_flag_q;
  logic rcf_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cpf_q <= 1'b0;
    end else begin
      cpf_q <= (cpf_q & ~devRead) | chargePumpEvent;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      clock_fail_flag_q <= 1'b0;
    end else begin
      clock_fail_flag_q <= (clock_fail_flag_q & ~devRead) | clockFailEvent;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tmf_q <= 1'b0;
    end else begin
      tmf_q <= (tmf_q & ~devRead) | testModeEvent;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ovf_q <= 1'b0;
    end else begin
      ovf_q <= (ovf_q & ~devRead) | overvoltageEvent;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      uvf_q <= 1'b0;
    end else begin
      uvf_q <= (uvf_q & ~devRead) | undervoltageEvent;
    end
  end

  // a frame of wrong length marks the link as failed
  always_ff @(posedge core_clk) begin
    if (rst) begin
      serial_link_fail_flag_q <= 1'b0;
    end else begin
      serial_link_fail_flag_q <= (serial_link_fail_flag_q & ~devRead) | (frameEnd & ~frameOk);
    end
  end

  // reset returns all serial registers, flag the fact
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rcf_q <= 1'b1;
    end else if (devRead) begin
      rcf_q <= 1'b0;
    end
  end

  // summaries
  logic [NUM_CH-1:0] ocAny;
  logic [NUM_CH-1:0] chSummary;
  logic              device_summary_flag;
  logic              overload_flag;
  logic              open_load_global_flag;
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      ocAny[i] = |ocCode_q[i];
    end
    chSummary = ocAny | ots_q | otw_q | olOn_q | olOff_q;
    device_summary_flag  = rcf_q | uvf_q | ovf_q | cpf_q | clock_fail_flag_q | tmf_q;
    overload_flag = |(ocAny | ots_q);
    open_load_global_flag  = |(olOn_q | olOff_q);
  end

  // word assembly for one address
  function automatic logic [WORD_W-1:0] buildWord(input logic [3:0] addr);
    logic [WORD_W-1:0] w;
    int ch;
    w  = '0;
    ch = 0;
    w[ADDR_MSB:ADDR_LSB] = (addr == ADDR_INIT1) ? ADDR_QUICK : addr;
    w[FAIL_BIT]          = failMode;
    if (addr <= ADDR_DEVICE) begin
      w[DSF_BIT]  = device_summary_flag;
      w[OVERLOAD_FLAG_BIT] = overload_flag;
      w[OLF_BIT]  = open_load_global_flag;
    end
    if (addr == ADDR_INIT1 || addr == ADDR_QUICK) begin
      w[Q_CPF_BIT]    = cpf_q;
      w[Q_RCF_BIT]    = rcf_q;
      w[Q_CLOCK_FAIL_FLAG_BIT]   = clock_fail_flag_q;
      w[NUM_CH-1:0]   = chSummary;
    end else if (addr >= ADDR_CH1 && addr <= ADDR_CH5) begin
      ch = int'(addr - ADDR_CH1);
      w[C_OTS_BIT]       = ots_q[ch];
      w[C_OTW_BIT]       = otw_q[ch];
      w[C_OC_LSB +: 3]   = ocCode_q[ch];
      w[C_OLON_BIT]      = olOn_q[ch];
      w[C_OLOFF_BIT]     = olOff_q[ch];
    end else if (addr == ADDR_DEVICE) begin
      w[D_TMF_BIT]  = tmf_q;
      w[D_OVF_BIT]  = ovf_q;
      w[D_UVF_BIT]  = uvf_q;
      w[D_SERIAL_LINK_FAIL_FLAG_BIT] = serial_link_fail_flag_q;
      w[D_LIMP_BIT] = limpLive;
    end else if (addr == ADDR_PINS) begin
      w[P_TOGGLE_BIT]       = |toggleLive;
      w[P_IN_LSB +: NUM_IN] = ctrlLive;
      w[NUM_CH-1:0]         = uvf_q ? '0 : outLive;
    end else if (addr == ADDR_PART_ID) begin
      w[7:0] = uvf_q ? 8'h00 : PART_CODE;
    end
    return w;
  endfunction

  // snapshot refreshed only while chip select is settled high
  always_ff @(posedge core_clk) begin
    if (rst) begin
      snapAddr_q <= SEL_RESET;
      snapWord_q <= '0;
    end else if (csSync2_q && csPrev_q) begin
      snapAddr_q <= readSel_q;
      snapWord_q <= buildWord(readSel_q);
    end
  end

endmodule

// File: sim/host_spi_model.sv
// host side of the serial link: sends frames of a chosen length, msb first
// assumes the device samples on rising edges and shifts out after falling edges
module host_spi_model (
  output logic      spiClk,
  output logic      chipSelN,
  output logic      serialIn,
  input  wire logic serialOut
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    spiClk   = 1'b0;
    chipSelN = 1'b1;
    serialIn = 1'b1;
  end
  // link clock runs only inside a frame; released data line shows the inverse of its last bit
  task automatic xfer(input logic [15:0] w, input int nBits, output logic [15:0] r);
    r = 16'h0000;
    #7 chipSelN = 1'b0;
    serialIn = w[15];
    #80;
    for (int k = 0; k < nBits; k++) begin
      spiClk = 1'b1;
      r = {r[14:0], serialOut};
      #80 spiClk = 1'b0;
      serialIn = (k < 15) ? w[14-k] : ~serialIn;
      #80;
    end
    chipSelN = 1'b1;
    serialIn = ~serialIn;
    #240;
  endtask
endmodule

// File: sim/readback_checker_sva.sv
// assertions on the status read-back block, watching its ports
// assumes 16-bit frames and a link clock that stands low between frames
module readback_checker_sva (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       spiClk,
  input wire logic       chipSelN,
  input wire logic       serialOut,
  input wire logic       serialOutEn,
  input wire logic       failMode,
  input wire logic       sleepMode,
  input wire logic       feedbackEnable
);
  logic [15:0] capQ;
  logic [4:0]  cntQ;
  wire logic [3:0] addrNib = capQ[15:12];
  wire logic       chanWord = (addrNib >= 4'h2) && (addrNib <= 4'h6);
  // bit count restarts when a frame opens
  always_ff @(posedge spiClk or negedge chipSelN) begin
    if (!spiClk) cntQ <= 5'h00;
    else cntQ <= cntQ + 5'h01;
  end
  always_ff @(posedge spiClk) begin
    capQ <= {capQ[14:0], serialOut};
  end
  addr_nibble_a: assert property (@(posedge chipSelN) disable iff (rst)
    cntQ == 5'h10 |-> addrNib != 4'h0) else $error("word carries address zero");
  chan_reserved_a: assert property (@(posedge chipSelN) disable iff (rst)
    cntQ == 5'h10 && chanWord |-> !capQ[7] && capQ[4:2] != 3'h7) else $error("bad channel word field");
  chan_overload_a: assert property (@(posedge chipSelN) disable iff (rst)
    cntQ == 5'h10 && chanWord && (capQ[6] || capQ[4:2] != 3'h0) |-> capQ[9]) else $error("overload flag missing");
  chan_openload_a: assert property (@(posedge chipSelN) disable iff (rst)
    cntQ == 5'h10 && chanWord && (|capQ[1:0]) |-> capQ[8]) else $error("open load flag missing");
  quick_summary_a: assert property (@(posedge chipSelN) disable iff (rst)
    cntQ == 5'h10 && addrNib == 4'h1 && (|capQ[7:5]) |-> capQ[10]) else $error("summary flag missing");
  dev_word_a: assert property (@(posedge chipSelN) disable iff (rst)
    cntQ == 5'h10 && addrNib == 4'h7 |-> capQ[7:5] == 3'h0 && (capQ[10] || !(capQ[4] || capQ[2])))
    else $error("device word malformed");
  id_zeros_a: assert property (@(posedge chipSelN) disable iff (rst)
    cntQ == 5'h10 && addrNib == 4'h9 |-> capQ[11:8] == 4'h0) else $error("id word upper bits set");
  feedback_gate_a: assert property (@(posedge core_clk) disable iff (rst)
    !$past(rst) |-> feedbackEnable == (!$past(failMode) && !$past(sleepMode))) else $error("feedback gate wrong");
  idle_quiet_a: assert property (@(posedge core_clk) disable iff (rst)
    chipSelN |-> !serialOut && !serialOutEn) else $error("output active outside frame");
  cover property (@(posedge chipSelN) cntQ == 5'h10 && chanWord && capQ[4:2] == 3'h6);
  cover property (@(posedge chipSelN) cntQ == 5'h10 && addrNib == 4'h7 && capQ[1]);
  cover property (@(posedge chipSelN) cntQ == 5'h10 && addrNib == 4'h9);
endmodule
bind fault_readback readback_checker_sva i_readback_checker_sva (.core_clk(core_clk), .rst(rst),
  .spiClk(spiClk), .chipSelN(chipSelN), .serialOut(serialOut), .serialOutEn(serialOutEn),
  .failMode(failMode), .sleepMode(sleepMode), .feedbackEnable(feedbackEnable));

// File: sim/testbench.sv
// self-checking bench for the status read-back block
// assumes the host model drives the link; fault inputs change at core clock falling edges
module testbench import fault_readback_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  logic                core_clk, rst, spiClk, chipSelN, serialIn, serialOut, serialOutEn;
  logic                failMode, sleepMode, chargePumpEvent, clockFailEvent, testModeEvent;
  logic                overvoltageEvent, undervoltageEvent, limpHomePin, feedbackEnable;
  logic [NUM_CH-1:0]   ocEvent, thermalShutdownEvent, thermalWarningEvent, openLoadOnEvent;
  logic [NUM_CH-1:0]   openLoadOffEvent, outputPinPin;
  logic [3*NUM_CH-1:0] ocEventCode;
  logic [NUM_IN-1:0]   controlInputPin, inputTogglePin;
  logic [2:0]          senseRouteSelect;
  int                  nMismatch, samplesChecked;
  fault_readback i_fault_readback (.*);
  host_spi_model i_host_spi_model (.spiClk(spiClk), .chipSelN(chipSelN), .serialIn(serialIn),
    .serialOut(serialOut));
  always #10 core_clk = ~core_clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nMismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [15:0] w, input logic [15:0] exp);
    logic [15:0] r;
    i_host_spi_model.xfer(w, 16, r);
    chk(r, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic doReset();
    rst = 1'b1;
    cyc(4);
    rst = 1'b0;
    cyc(4);
  endtask
  task automatic selectSingle();
    rd(16'h1000, 16'h1440);
    rd(16'h0007, 16'h1440);
    rd(16'h1000, 16'h7400);
    rd(16'h1000, 16'h1000);
  endtask
  task automatic stickyPins();
    cyc(1);
    controlInputPin = 4'ha;
    inputTogglePin  = 4'h2;
    outputPinPin    = 5'h15;
    cyc(6);
    rd(16'h0018, 16'h1000);
    rd(16'h1000, 16'h8355);
    cyc(1);
    outputPinPin   = 5'h0a;
    inputTogglePin = 4'h0;
    cyc(6);
    rd(16'h0010, 16'h814a);
    rd(16'h1000, 16'h1000);
    rd(16'h0009, 16'h1000);
    rd(16'h1000, 16'h905a);
  endtask
  task automatic fireOc(input logic [2:0] code);
    cyc(1);
    ocEvent     = 5'h01;
    ocEventCode = {12'h000, code};
    cyc(1);
    ocEvent = 5'h00;
  endtask
  task automatic ocCodes();
    for (int c = 1; c < 7; c++) begin
      fireOc(3'(7 - c));
      fireOc(3'(c));
      cyc(4);
      rd(16'h0002, 16'h1201);
      rd(16'h1000, 16'h2200 | 16'(c << 2));
    end
    rd(16'h1000, 16'h1000);
  endtask
  task automatic thermalOpen();
    cyc(1);
    {thermalShutdownEvent, thermalWarningEvent, openLoadOnEvent, openLoadOffEvent} = 20'h84042;
    cyc(1);
    {thermalShutdownEvent, thermalWarningEvent, openLoadOnEvent, openLoadOffEvent} = 20'h00000;
    cyc(4);
    rd(16'h0006, 16'h1312);
    rd(16'h1000, 16'h6360);
    rd(16'h0003, 16'h1102);
    rd(16'h1000, 16'h3103);
    rd(16'h1000, 16'h1000);
  endtask
  task automatic deviceFaults();
    cyc(1);
    limpHomePin = 1'b1;
    {chargePumpEvent, clockFailEvent, testModeEvent, overvoltageEvent, undervoltageEvent} = 5'h1f;
    cyc(1);
    {chargePumpEvent, clockFailEvent, testModeEvent, overvoltageEvent, undervoltageEvent} = 5'h00;
    cyc(4);
    rd(16'h0009, 16'h14a0);
    rd(16'h0008, 16'h9000);
    rd(16'h0007, 16'h8140);
    rd(16'h1000, 16'h741d);
    cyc(1);
    limpHomePin = 1'b0;
    cyc(6);
    rd(16'h0007, 16'h1000);
    rd(16'h1000, 16'h7000);
    // test flag was read as set, so the host resets the device
    doReset();
  endtask
  task automatic failRoute();
    rd(16'h00a1, 16'h1440);
    cyc(2);
    chk({13'h0000, senseRouteSelect}, 16'h0005);
    chk({15'h0000, feedbackEnable}, 16'h0001);
    failMode = 1'b1;
    cyc(4);
    chk({15'h0000, feedbackEnable}, 16'h0000);
    rd(16'h1000, 16'h1c40);
    cyc(1);
    failMode  = 1'b0;
    sleepMode = 1'b1;
    cyc(2);
    chk({15'h0000, feedbackEnable}, 16'h0000);
    sleepMode = 1'b0;
    cyc(4);
  endtask
  task automatic linkFail();
    logic [15:0] r;
    i_host_spi_model.xfer(16'h0000, 8, r);
    rd(16'h0007, 16'h1440);
    rd(16'h1000, 16'h7402);
    rd(16'h1000, 16'h1000);
  endtask
  task automatic printVerdict();
    if (nMismatch == 0 && samplesChecked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    rst      = 1'b1;
    {failMode, sleepMode, chargePumpEvent, clockFailEvent, testModeEvent} = 5'h00;
    {overvoltageEvent, undervoltageEvent, limpHomePin, ocEvent, ocEventCode} = 23'h000000;
    {thermalShutdownEvent, thermalWarningEvent, openLoadOnEvent, openLoadOffEvent} = 20'h00000;
    {outputPinPin, controlInputPin, inputTogglePin} = 13'h0000;
    doReset();
    selectSingle();
    stickyPins();
    ocCodes();
    thermalOpen();
    deviceFaults();
    failRoute();
    linkFail();
    printVerdict();
  end
  initial begin
    #500us;
    nMismatch++;
    printVerdict();
  end
endmodule
